// file: hdl/rcr_consts.svh
// Address map, bit positions, masks and reset values of the reference control block.
// Included by the package, the top module and the bench; holds definitions only.
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH

// Register indices; the byte address is four times the index
`define RCR_BGC_IDX        8'h98
`define RCR_LRC_IDX        8'h99
`define RCR_IDX_W          8

// Ladder reference control fields
`define RCR_LRC_CMP1_SEL   7
`define RCR_LRC_CMP2_SEL   6
`define RCR_LRC_RANGE_LOW  5
`define RCR_LRC_VAL_HI     3
`define RCR_LRC_VAL_LO     0
`define RCR_LRC_WMASK      8'hef
`define RCR_LRC_RESET      8'h00

// Bandgap reference control fields
`define RCR_BGC_STABLE     5
`define RCR_BGC_BYPASS     4
`define RCR_BGC_ENABLE     3
`define RCR_BGC_BG_PIN     2
`define RCR_BGC_LAD_PIN    1
`define RCR_BGC_WMASK      8'h1e
`define RCR_BGC_RESET      8'h00

`define RCR_TAP_ZERO       4'h0
`define RCR_HRDATA_PAD     24'h000000
`define RCR_HADDR_PAD      22'h000000
`define RCR_HTRANS_BUSY_B  1

`endif

// file: hdl/rcr_pkg.sv
// Types shared by the reference control block.
// Assumes rcr_consts.svh is on the include path.
`include "rcr_consts.svh"

package rcr_pkg;
   typedef logic [7:0]                reg8_t;
   typedef logic [`RCR_IDX_W-1:0]     rcr_idx_t;
   typedef logic [3:0]                rcr_tap_t;
   typedef enum logic [1:0] {
      RCR_SEL_NONE,
      RCR_SEL_BGC,
      RCR_SEL_LRC
   } rcr_sel_t;
endpackage

// file: hdl/rcr_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous level.
// Assumes the input is quasi-static compared with hclk.
`timescale 1ns/1ps

module rcr_sync (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic async_in,
   output logic      level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Only accept a change once the last two stages agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule

// file: hdl/rcr_top.sv
// Reference control registers: ladder and bandgap reference control over AHB-Lite.
// Assumes one AHB-Lite master, single word transfers, and an analog macro that
// takes the registered control outputs and returns an asynchronous stable level.
//
// How it works
// RQ1 - Reset clears both registers, so every reference control starts off except buffer power and the high voltage bandgap enable;
// here buffer_power_en is held at 0 while hresetn is low and goes to 1 on the first clock after reset.
// RQ2 - Ladder bit 5 set selects low range, clear selects high range.
// RQ3 - Ladder bits 3..0 hold tap value 0..15 that drives the ladder tap.
// RQ4 - Ladder bit 7 powers the ladder and routes it to comparator 1, else bandgap.
// RQ5 - Ladder bit 6 powers the ladder and routes it to comparator 2, else bandgap.
// RQ6 - Ladder power is off only when both selects and ladder pin bit are zero.
// RQ7 - Powered down ladder with zero value and low range ties output to ground.
// RQ8 - Bandgap bit 5 reads the synchronised stable indication, read only.
// RQ9 - Bypass bit 4 routes output unbuffered and removes buffer power.
// RQ10 - Bandgap bit 3 turns the fixed reference on, clear fully disables it.
// RQ11 - With ladder pin bit clear, bit 2 puts bandgap on the pin.
// RQ12 - Bit 1 puts the ladder on the pin and overrides bit 2.
// RQ13 - High voltage variant holds the bandgap enable at one always.
// RQ14 - Unimplemented bits read zero: ladder bit 4, bandgap bits 7, 6, 0.
// RQ15 - Software waits the settling time after enabling before using the reference.
// RQ16 - Writes to read only or unimplemented bits leave other bits unchanged.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rcr_consts.svh"

module rcr_top
   import rcr_pkg::*;
#(
   parameter bit HIGH_VOLTAGE = 1'b0
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        bandgap_stable_in,
   output logic [3:0]       ladder_value,
   output logic             ladder_range_low,
   output logic             ladder_power_en,
   output logic             ladder_to_ground,
   output logic             cmp1_ref_input_ladder,
   output logic             cmp2_ref_input_ladder,
   output logic             bandgap_enable,
   output logic             buffer_bypass,
   output logic             buffer_power_en,
   output logic             pin_drive_ladder,
   output logic             pin_drive_bandgap
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic rcr_sel_t decode(input logic [31:0] a);
      rcr_sel_t s;
      s = RCR_SEL_NONE;
      if (a == {`RCR_HADDR_PAD, `RCR_BGC_IDX, 2'b00}) begin
         s = RCR_SEL_BGC;
      end else if (a == {`RCR_HADDR_PAD, `RCR_LRC_IDX, 2'b00}) begin
         s = RCR_SEL_LRC;
      end
      return s;
   endfunction

   logic     access;
   rcr_sel_t addr_sel;
   rcr_sel_t wr_sel;
   logic     wr_pend;
   reg8_t    lrc;
   reg8_t    bgc;
   reg8_t    next_lrc;
   reg8_t    next_bgc;
   reg8_t    next_bgc_view;
   logic     stable;

   // hsize is not checked: only whole word transfers are issued
   assign access   = hsel && hready && htrans[`RCR_HTRANS_BUSY_B];
   assign addr_sel = decode(haddr);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, always OKAY

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_sel  <= RCR_SEL_NONE;
      end else if (hready) begin
         wr_pend <= access && hwrite;
         wr_sel  <= addr_sel;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read data built from next_ values so a write just completing is seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (access && !hwrite) begin
         unique case (addr_sel)
            RCR_SEL_BGC:  hrdata <= {`RCR_HRDATA_PAD, next_bgc_view};      // [RQ8] [RQ14]
            RCR_SEL_LRC:  hrdata <= {`RCR_HRDATA_PAD, next_lrc};           // [RQ14]
            RCR_SEL_NONE: hrdata <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file

   always_comb begin
      next_lrc = lrc;
      if (wr_pend && wr_sel == RCR_SEL_LRC) begin
         next_lrc = hwdata[7:0] & `RCR_LRC_WMASK;                         // [RQ16] [RQ14]
      end
   end

   always_comb begin
      next_bgc = bgc;
      if (wr_pend && wr_sel == RCR_SEL_BGC) begin
         next_bgc = hwdata[7:0] & `RCR_BGC_WMASK;                         // [RQ16] [RQ14]
      end
      next_bgc_view = next_bgc;
      next_bgc_view[`RCR_BGC_STABLE] = stable;                            // [RQ8]
      if (HIGH_VOLTAGE) begin
         next_bgc_view[`RCR_BGC_ENABLE] = 1'b1;                           // [RQ13]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lrc <= `RCR_LRC_RESET;                                           // [RQ1]
         bgc <= `RCR_BGC_RESET;                                           // [RQ1]
      end else begin
         lrc <= next_lrc;
         bgc <= next_bgc;
      end
   end

   rcr_sync u_stable_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (bandgap_stable_in),
      .level    (stable)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Analog controls, registered from the next_ values to track the registers

   logic next_ladder_power;
   assign next_ladder_power = next_lrc[`RCR_LRC_CMP1_SEL] | next_lrc[`RCR_LRC_CMP2_SEL]
                              | next_bgc[`RCR_BGC_LAD_PIN];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ladder_value          <= `RCR_TAP_ZERO;
         ladder_range_low      <= 1'b0;
         ladder_power_en       <= 1'b0;
         ladder_to_ground      <= 1'b0;
         cmp1_ref_input_ladder <= 1'b0;
         cmp2_ref_input_ladder <= 1'b0;
      end else begin
         ladder_value          <= next_lrc[`RCR_LRC_VAL_HI:`RCR_LRC_VAL_LO];      // [RQ3]
         ladder_range_low      <= next_lrc[`RCR_LRC_RANGE_LOW];                   // [RQ2]
         ladder_power_en       <= next_ladder_power;                              // [RQ6]
         // Ground tap lets comparators see zero crossing without ladder current
         ladder_to_ground      <= !next_ladder_power && next_lrc[`RCR_LRC_RANGE_LOW]
                                  && next_lrc[`RCR_LRC_VAL_HI:`RCR_LRC_VAL_LO]
                                     == `RCR_TAP_ZERO;                            // [RQ7]
         cmp1_ref_input_ladder <= next_lrc[`RCR_LRC_CMP1_SEL];                    // [RQ4]
         cmp2_ref_input_ladder <= next_lrc[`RCR_LRC_CMP2_SEL];                    // [RQ5]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // High voltage part never shows the reference off, reset included
         bandgap_enable    <= HIGH_VOLTAGE;                                       // [RQ13]
         buffer_bypass     <= 1'b0;
         buffer_power_en   <= 1'b0;
         pin_drive_ladder  <= 1'b0;
         pin_drive_bandgap <= 1'b0;
      end else begin
         // Settling after enable is left to software
         bandgap_enable    <= next_bgc_view[`RCR_BGC_ENABLE];                     // [RQ10] [RQ13]
         buffer_bypass     <= next_bgc[`RCR_BGC_BYPASS];                          // [RQ9]
         buffer_power_en   <= !next_bgc[`RCR_BGC_BYPASS];                         // [RQ9]
         pin_drive_ladder  <= next_bgc[`RCR_BGC_LAD_PIN];                         // [RQ12]
         pin_drive_bandgap <= next_bgc[`RCR_BGC_BG_PIN]
                              && !next_bgc[`RCR_BGC_LAD_PIN];                     // [RQ11] [RQ12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_wr_lrc;
      wr_pend && wr_sel == RCR_SEL_LRC;
   endsequence

   sequence s_wr_bgc;
      wr_pend && wr_sel == RCR_SEL_BGC;
   endsequence

   sequence s_rd_lrc;
      access && !hwrite && addr_sel == RCR_SEL_LRC;
   endsequence

   sequence s_rd_bgc;
      access && !hwrite && addr_sel == RCR_SEL_BGC;
   endsequence

   sequence s_raw_high;
      bandgap_stable_in [*4];
   endsequence

   property p_tap;
      s_wr_lrc |=> ladder_value == $past(hwdata[3:0]);
   endproperty
   a_tap: assert property (p_tap) else $error("ladder tap not updated");          // [RQ3]

   property p_range;
      s_wr_lrc |=> ladder_range_low == $past(hwdata[5]);
   endproperty
   a_range: assert property (p_range) else $error("range bit not updated");       // [RQ2]

   property p_cmp_sel;
      s_wr_lrc |=> cmp1_ref_input_ladder == $past(hwdata[7])
                   && cmp2_ref_input_ladder == $past(hwdata[6]);
   endproperty
   a_cmp_sel: assert property (p_cmp_sel) else $error("comparator routing wrong"); // [RQ4] [RQ5]

   property p_power;
      ladder_power_en == (cmp1_ref_input_ladder | cmp2_ref_input_ladder
                          | pin_drive_ladder);
   endproperty
   a_power: assert property (p_power) else $error("ladder power wrong");          // [RQ6]

   property p_ground;
      ladder_to_ground |-> !ladder_power_en && ladder_range_low
                           && ladder_value == `RCR_TAP_ZERO;
   endproperty
   a_ground: assert property (p_ground) else $error("ground tap wrong");          // [RQ7]

   logic bgc_view_stable;
   assign bgc_view_stable = stable;
   property p_stable;
      s_raw_high ##1 1'b1 |-> bgc_view_stable;
   endproperty
   a_stable: assert property (p_stable) else $error("stable flag late");          // [RQ8]

   property p_bypass;
      s_wr_bgc |=> buffer_bypass == $past(hwdata[4]) && buffer_power_en != buffer_bypass;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass wrong");              // [RQ9]

   property p_pin;
      s_wr_bgc |=> pin_drive_bandgap == ($past(hwdata[2]) && !$past(hwdata[1]))
                   && pin_drive_ladder == $past(hwdata[1]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin source wrong");                // [RQ11] [RQ12]

   property p_hv;
      HIGH_VOLTAGE |-> bandgap_enable ##1 bandgap_enable;
   endproperty
   a_hv: assert property (p_hv) else $error("bandgap enable not forced");         // [RQ13]

   property p_unimpl;
      s_rd_lrc |=> hrdata[4] == 1'b0 && hrdata[31:8] == `RCR_HRDATA_PAD;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read one"); // [RQ14]

   property p_store;
      (bgc & ~`RCR_BGC_WMASK) == 8'h00 && (lrc & ~`RCR_LRC_WMASK) == 8'h00;
   endproperty
   a_store: assert property (p_store) else $error("read only bit stored");       // [RQ16]

   property p_enable;
      s_wr_bgc |=> bandgap_enable == ($past(hwdata[3]) || HIGH_VOLTAGE);
   endproperty
   a_enable: assert property (p_enable) else $error("bandgap enable wrong");      // [RQ10] [RQ13]

   property p_stable_read;
      s_rd_bgc |=> hrdata[5] == $past(stable) && hrdata[7:6] == 2'b00
                   && hrdata[0] == 1'b0;
   endproperty
   a_stable_read: assert property (p_stable_read) else $error("stable read wrong"); // [RQ8] [RQ14]

endmodule

// file: sim/tb_top.sv
// Self-checking bench for the reference control registers.
// Assumes rcr_top on AHB-Lite with zero wait states and rcr_consts.svh on the include path.
`timescale 1ns/1ps
`include "rcr_consts.svh"

module tb_top import rcr_pkg::*;;
   typedef struct packed {
      reg8_t       lw;
      reg8_t       bw;
      reg8_t       lr;
      reg8_t       br;
      logic [13:0] o;
   } rcr_row_t;

   localparam logic [31:0] A_BGC = {`RCR_HADDR_PAD, `RCR_BGC_IDX, 2'b00};
   localparam logic [31:0] A_LRC = {`RCR_HADDR_PAD, `RCR_LRC_IDX, 2'b00};

   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        bandgap_stable_in = 1'b0;
   logic        hreadyout, hresp, hv_bg_en;
   logic [31:0] hrdata, rd;
   logic [3:0]  ladder_value;
   logic        ladder_range_low, ladder_power_en, ladder_to_ground, cmp1_ref_input_ladder;
   logic        cmp2_ref_input_ladder, bandgap_enable, buffer_bypass, buffer_power_en;
   logic        pin_drive_ladder, pin_drive_bandgap;
   logic [13:0] outs;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          k;
   // Value, range, power, ground, cmp1, cmp2, enable, bypass, buffer power, ladder pin, bg pin
   rcr_row_t    rows [8] = '{
      '{8'h00, 8'h00, 8'h00, 8'h00, 14'h0004}, '{8'h20, 8'h00, 8'h20, 8'h00, 14'h0284},
      '{8'hff, 8'hff, 8'hef, 8'h1e, 14'h3f7a}, '{8'h8a, 8'h04, 8'h8a, 8'h04, 14'h2945},
      '{8'h45, 8'h18, 8'h45, 8'h18, 14'h1538}, '{8'h30, 8'h02, 8'h20, 8'h02, 14'h0306},
      '{8'h01, 8'h06, 8'h01, 8'h06, 14'h0506}, '{8'h21, 8'he1, 8'h21, 8'h00, 14'h0604}};

   assign outs = {ladder_value, ladder_range_low, ladder_power_en, ladder_to_ground,
                  cmp1_ref_input_ladder, cmp2_ref_input_ladder, bandgap_enable,
                  buffer_bypass, buffer_power_en, pin_drive_ladder, pin_drive_bandgap};

   always #5 hclk = ~hclk;

   rcr_top i_rcr_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .bandgap_stable_in(bandgap_stable_in), .ladder_value(ladder_value),
      .ladder_range_low(ladder_range_low), .ladder_power_en(ladder_power_en),
      .ladder_to_ground(ladder_to_ground), .cmp1_ref_input_ladder(cmp1_ref_input_ladder),
      .cmp2_ref_input_ladder(cmp2_ref_input_ladder), .bandgap_enable(bandgap_enable),
      .buffer_bypass(buffer_bypass), .buffer_power_en(buffer_power_en),
      .pin_drive_ladder(pin_drive_ladder), .pin_drive_bandgap(pin_drive_bandgap));

   // Second copy only to watch the forced enable; its bus answers are not used
   rcr_top #(.HIGH_VOLTAGE(1'b1)) i_rcr_top_hv (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(), .hresp(), .hrdata(), .bandgap_stable_in(bandgap_stable_in),
      .ladder_value(), .ladder_range_low(), .ladder_power_en(), .ladder_to_ground(),
      .cmp1_ref_input_ladder(), .cmp2_ref_input_ladder(), .bandgap_enable(hv_bg_en),
      .buffer_bypass(), .buffer_power_en(), .pin_drive_ladder(), .pin_drive_bandgap());

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Bounded so a stuck slave ends the run instead of hanging it
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         tally_and_finish;
      end
   endtask

   // Entered just after a rising edge; returns just after the data phase edge
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rdv = hrdata;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, A_LRC, 32'h0, rd);
      check(rd, 32'h0);
      xfer(1'b0, A_BGC, 32'h0, rd);
      check(rd, 32'h0);
      check({18'h0, outs & 14'h3ffb}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, A_LRC, {24'h0, rows[i].lw}, rd);
         xfer(1'b1, A_BGC, {24'h0, rows[i].bw}, rd);
         xfer(1'b0, A_LRC, 32'h0, rd);
         check(rd, {24'h0, rows[i].lr});
         xfer(1'b0, A_BGC, 32'h0, rd);
         check(rd, {24'h0, rows[i].br});
         check({24'h0, outs[13:6]}, {24'h0, rows[i].o[13:6]});
         check({26'h0, outs[5:0]}, {26'h0, rows[i].o[5:0]});
         check({31'h0, hv_bg_en}, 32'h1);
      end
      // Unmapped places: printed offset used as byte address, and two words up
      xfer(1'b1, A_LRC + 32'h8, 32'hff, rd);
      xfer(1'b0, A_LRC + 32'h8, 32'h0, rd);
      check(rd, 32'h0);
      xfer(1'b0, {24'h0, `RCR_LRC_IDX}, 32'h0, rd);
      check(rd, 32'h0);
      xfer(1'b0, A_LRC, 32'h0, rd);
      check(rd, 32'h21);
      // Stable flag follows the input after synchronising; writes cannot clear it
      bandgap_stable_in <= 1'b1;
      k = 0;
      do begin
         xfer(1'b1, A_BGC, 32'h0, rd);
         xfer(1'b0, A_BGC, 32'h0, rd);
         k++;
      end while (rd[5] !== 1'b1 && k < 10);
      if (rd[5] !== 1'b1) begin
         n_mismatch++;
         tally_and_finish;
      end
      check(rd, 32'h20);
      bandgap_stable_in <= 1'b0;
      k = 0;
      do begin
         xfer(1'b0, A_BGC, 32'h0, rd);
         k++;
      end while (rd[5] !== 1'b0 && k < 10);
      if (rd[5] !== 1'b0) begin
         n_mismatch++;
         tally_and_finish;
      end
      check(rd, 32'h0);
      // Reset in mid-run with everything set
      xfer(1'b1, A_LRC, 32'hff, rd);
      xfer(1'b1, A_BGC, 32'h1e, rd);
      @(posedge hclk);
      check({18'h0, outs}, 32'h3f7a);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      check({18'h0, outs & 14'h3ffb}, 32'h0);
      check({31'h0, hv_bg_en}, 32'h1);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, A_LRC, 32'h0, rd);
      check(rd, 32'h0);
      xfer(1'b0, A_BGC, 32'h0, rd);
      check(rd, 32'h0);
      tally_and_finish;
   end
endmodule
